// ==== common/bdm_pkg.sv ====
// Functional notes
// R1: The active bank comes from bits 6 and 5 of the flags register, 00 to 11 picking banks 0 to 3.
// R2: Each bank spans in-bank offsets 00h to 7Fh, and the bank field plus the offset form the full address.
// R3: Low offsets of a bank decode to special function registers and higher offsets to RAM bytes.
// R4: Every implemented bank holds special function registers, and busy ones are shared across banks.
// R5: The register file is reached directly from the instruction or indirectly through the pointer.
// R6: Unimplemented locations read as zero and ignore writes.
// R7: The operand read happens in the second quarter and the destination write in the fourth.
// R8: Offset 00h of any bank is no real register and redirects to the address in the pointer.
`default_nettype none
package bdm_pkg;

  // Quarter phases of one instruction cycle.
  typedef enum logic [1:0] {QTR_1, QTR_2, QTR_3, QTR_4} bdm_quarter_type;

  // Address layout.
  localparam int OFF_W = 7;
  localparam int ADDR_W = 9;
  localparam int IDX_W = 8;
  localparam int FLAGS_BANK_HI = 6;
  localparam int FLAGS_BANK_LO = 5;
  localparam logic [1:0] FIRST_ABSENT_BANK = 2'h2;
  localparam logic [6:0] OFF_INDIRECT = 7'h00;
  localparam logic [6:0] GPR_BASE = 7'h20;
  localparam logic [6:0] GPR1_TOP = 7'h3F;

  // Storage layout: 64 SFR slots, then bank 0 RAM, then bank 1 RAM.
  localparam int MEM_DEPTH = 192;
  localparam logic [7:0] GPR0_SHIFT = 8'h20;
  localparam logic [7:0] GPR1_SHIFT = 8'h80;
  localparam logic [7:0] GPR0_BASE_IDX = 8'h40;
  localparam logic [7:0] SLOT_FLAGS = 8'h03;
  localparam logic [7:0] SLOT_POINTER = 8'h04;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Register addresses, bank 0.
  localparam logic [8:0] ADR_INDIRECT_DATA_B0 = 9'h000;
  localparam logic [8:0] ADR_TIMER0_COUNT = 9'h001;
  localparam logic [8:0] ADR_PC_LOW_B0 = 9'h002;
  localparam logic [8:0] ADR_CPU_FLAGS_B0 = 9'h003;
  localparam logic [8:0] ADR_INDIRECT_POINTER_B0 = 9'h004;
  localparam logic [8:0] ADR_PORT_A_LATCH = 9'h005;
  localparam logic [8:0] ADR_PORT_B_LATCH = 9'h006;
  localparam logic [8:0] ADR_PORT_C_LATCH = 9'h007;
  localparam logic [8:0] ADR_PC_HIGH_LATCH_B0 = 9'h00A;
  localparam logic [8:0] ADR_IRQ_CONTROL_B0 = 9'h00B;
  localparam logic [8:0] ADR_PERIPH_IRQ_FLAGS1 = 9'h00C;
  localparam logic [8:0] ADR_TIMER1_COUNT_LOW = 9'h00E;
  localparam logic [8:0] ADR_TIMER1_COUNT_HIGH = 9'h00F;
  localparam logic [8:0] ADR_TIMER1_CONTROL = 9'h010;
  localparam logic [8:0] ADR_TIMER2_COUNT = 9'h011;
  localparam logic [8:0] ADR_TIMER2_CONTROL = 9'h012;
  localparam logic [8:0] ADR_SERIAL_PORT_BUFFER = 9'h013;
  localparam logic [8:0] ADR_SERIAL_PORT_CONTROL = 9'h014;
  localparam logic [8:0] ADR_CCP1_VALUE_LOW = 9'h015;
  localparam logic [8:0] ADR_CCP1_VALUE_HIGH = 9'h016;
  localparam logic [8:0] ADR_CCP1_CONTROL = 9'h017;
  localparam logic [8:0] ADR_ADC_RESULT = 9'h01E;
  localparam logic [8:0] ADR_ADC_CONTROL0 = 9'h01F;

  // Register addresses, bank 1.
  localparam logic [8:0] ADR_INDIRECT_DATA_B1 = 9'h080;
  localparam logic [8:0] ADR_CORE_OPTIONS = 9'h081;
  localparam logic [8:0] ADR_PC_LOW_B1 = 9'h082;
  localparam logic [8:0] ADR_CPU_FLAGS_B1 = 9'h083;
  localparam logic [8:0] ADR_INDIRECT_POINTER_B1 = 9'h084;
  localparam logic [8:0] ADR_PORT_A_DIRECTION = 9'h085;
  localparam logic [8:0] ADR_PORT_B_DIRECTION = 9'h086;
  localparam logic [8:0] ADR_PORT_C_DIRECTION = 9'h087;
  localparam logic [8:0] ADR_PC_HIGH_LATCH_B1 = 9'h08A;
  localparam logic [8:0] ADR_IRQ_CONTROL_B1 = 9'h08B;
  localparam logic [8:0] ADR_PERIPH_IRQ_ENABLES1 = 9'h08C;
  localparam logic [8:0] ADR_POWER_CONTROL = 9'h08E;
  localparam logic [8:0] ADR_TIMER2_PERIOD = 9'h092;
  localparam logic [8:0] ADR_SERIAL_PORT_SLAVE_ADDR = 9'h093;
  localparam logic [8:0] ADR_SERIAL_PORT_STATE = 9'h094;
  localparam logic [8:0] ADR_ADC_CONTROL1 = 9'h09F;

endpackage : bdm_pkg
`default_nettype wire

// ==== src/bdm_quarter.sv ====
`timescale 1ns/1ns
`default_nettype none
module bdm_quarter
  import bdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [1:0] quarter_o,
  output logic read_phase_o,
  output logic write_phase_o
);

  bdm_quarter_type quarter;
  bdm_quarter_type next_quarter;

  // The four quarters simply rotate; reset restarts a cycle at its first quarter.
  always_comb
  begin
    unique case (quarter)
      QTR_1: next_quarter = QTR_2;
      QTR_2: next_quarter = QTR_3;
      QTR_3: next_quarter = QTR_4;
      QTR_4: next_quarter = QTR_1;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      quarter <= QTR_1;
    else
      quarter <= next_quarter;
  end

  // Phase strobes for the operand read and the destination write.
  assign quarter_o = quarter;
  assign read_phase_o = (quarter == QTR_2); // see R7
  assign write_phase_o = (quarter == QTR_4); // see R7

endmodule : bdm_quarter
`default_nettype wire

// ==== src/bdm_byte_store.sv ====
`timescale 1ns/1ns
`default_nettype none
module bdm_byte_store
  import bdm_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH,
  parameter int TAP_A = 3,
  parameter int TAP_B = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] ridx_i,
  output logic [7:0] rdata_o,
  input wire logic we_i,
  input wire logic [7:0] widx_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] tap_a_o,
  output logic [7:0] tap_b_o
);

  logic [7:0] mem [DEPTH];

  // One flip-flop byte per entry, written only when its own index is addressed.
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_byte
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        mem[i] <= RESET_BYTE;
      else if (we_i && (widx_i == 8'(i)))
        mem[i] <= wdata_i;
    end
  end

  // Indexes past the end come only from missed targets, which are masked upstream; they read zero.
  assign rdata_o = (int'(ridx_i) < DEPTH) ? mem[ridx_i] : ZERO_BYTE;
  assign tap_a_o = mem[TAP_A];
  assign tap_b_o = mem[TAP_B];

endmodule : bdm_byte_store
`default_nettype wire

// ==== src/bdm_data_map.sv ====
`timescale 1ns/1ns
`default_nettype none
// Banked data memory decoder and storage seen by the core's operand path.
module bdm_data_map
  import bdm_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [6:0] OP_ADDR_I,
  input wire logic [7:0] OP_WDATA_I,
  input wire logic OP_WE_I,
  output logic [7:0] OP_RDATA_O,
  output logic [1:0] QUARTER_O,
  output logic [8:0] EFF_ADDR_O,
  output logic EFF_HIT_O,
  output logic [1:0] BANK_SEL_O,
  output logic [7:0] POINTER_O
);

  logic read_phase;
  logic write_phase;
  logic [7:0] flags;
  logic [7:0] pointer;
  logic [1:0] bank_sel;
  logic is_indirect;
  logic [8:0] direct_addr;
  logic [8:0] indirect_addr;
  logic [8:0] req_addr;
  logic [1:0] req_bank;
  logic [6:0] req_off;
  logic bank_ok;
  logic is_gpr_off;
  logic gpr_hit;
  logic sfr_hit;
  logic is_mirror;
  logic req_hit;
  logic [7:0] sfr_idx;
  logic [7:0] gpr_idx;
  logic [7:0] req_idx;
  logic [7:0] rd_byte;
  logic store_we;
  logic [7:0] lat_idx;
  logic lat_hit;
  logic [7:0] next_rdata;

  // Quarter sequencer: one instruction cycle is four clocks.
  bdm_quarter bdm_quarter_i (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .quarter_o(QUARTER_O),
    .read_phase_o(read_phase),
    .write_phase_o(write_phase)
  );

  // Bank field and pointer are read straight from their storage bytes.
  // Taking them from the store taps means a write is seen by the very next decode.
  assign bank_sel = flags[FLAGS_BANK_HI:FLAGS_BANK_LO]; // see R1
  assign BANK_SEL_O = bank_sel;
  assign POINTER_O = pointer;

  // Direct and indirect address formation.
  // The pointer's top bit picks the bank within a pair, and the
  // bank high bit picks the pair, so all four banks stay reachable.
  assign is_indirect = (OP_ADDR_I == OFF_INDIRECT); // see R8
  assign direct_addr = {bank_sel, OP_ADDR_I}; // see R2
  assign indirect_addr = {flags[FLAGS_BANK_HI], pointer}; // see R5
  assign req_addr = is_indirect ? indirect_addr : direct_addr; // see R5
  assign req_bank = req_addr[8:7];
  assign req_off = req_addr[6:0];

  // Presence table of the physical special function registers.
  // The indirect data port is deliberately absent: it holds nothing.
  function automatic logic sfr_present(input logic [8:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      ADR_TIMER0_COUNT,
      ADR_PC_LOW_B0,
      ADR_CPU_FLAGS_B0,
      ADR_INDIRECT_POINTER_B0,
      ADR_PORT_A_LATCH,
      ADR_PORT_B_LATCH,
      ADR_PORT_C_LATCH,
      ADR_PC_HIGH_LATCH_B0,
      ADR_IRQ_CONTROL_B0,
      ADR_PERIPH_IRQ_FLAGS1,
      ADR_TIMER1_COUNT_LOW,
      ADR_TIMER1_COUNT_HIGH,
      ADR_TIMER1_CONTROL,
      ADR_TIMER2_COUNT,
      ADR_TIMER2_CONTROL,
      ADR_SERIAL_PORT_BUFFER,
      ADR_SERIAL_PORT_CONTROL,
      ADR_CCP1_VALUE_LOW,
      ADR_CCP1_VALUE_HIGH,
      ADR_CCP1_CONTROL,
      ADR_ADC_RESULT,
      ADR_ADC_CONTROL0,
      ADR_CORE_OPTIONS,
      ADR_PC_LOW_B1,
      ADR_CPU_FLAGS_B1,
      ADR_INDIRECT_POINTER_B1,
      ADR_PORT_A_DIRECTION,
      ADR_PORT_B_DIRECTION,
      ADR_PORT_C_DIRECTION,
      ADR_PC_HIGH_LATCH_B1,
      ADR_IRQ_CONTROL_B1,
      ADR_PERIPH_IRQ_ENABLES1,
      ADR_POWER_CONTROL,
      ADR_TIMER2_PERIOD,
      ADR_SERIAL_PORT_SLAVE_ADDR,
      ADR_SERIAL_PORT_STATE,
      ADR_ADC_CONTROL1: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : sfr_present

  // Offsets whose register is shared by both banks.
  function automatic logic sfr_mirrored(input logic [6:0] off);
    logic shared;
    shared = 1'b0;
    case (off)
      ADR_PC_LOW_B0[6:0],
      ADR_CPU_FLAGS_B0[6:0],
      ADR_INDIRECT_POINTER_B0[6:0],
      ADR_PC_HIGH_LATCH_B0[6:0],
      ADR_IRQ_CONTROL_B0[6:0]: shared = 1'b1;
      default: shared = 1'b0;
    endcase
    return shared;
  endfunction : sfr_mirrored

  // Region decode. Banks 2 and 3 can be selected but are not built.
  // A bank 1 offset past its small RAM block falls through to a miss.
  assign bank_ok = (req_bank < FIRST_ABSENT_BANK); // see R1
  assign is_gpr_off = (req_off >= GPR_BASE); // see R3
  assign gpr_hit = bank_ok && is_gpr_off && (!req_bank[0] || (req_off <= GPR1_TOP)); // see R3
  assign sfr_hit = bank_ok && !is_gpr_off && sfr_present(req_addr); // see R4
  assign is_mirror = sfr_mirrored(req_off); // see R4
  assign req_hit = sfr_hit || gpr_hit; // see R6

  // Storage index: a mirrored register folds onto its bank 0 slot.
  // Folding keeps one byte per shared register, so the two banks can never disagree.
  assign sfr_idx = {2'b00, req_bank[0] & ~is_mirror, req_off[4:0]}; // see R4
  assign gpr_idx = {1'b0, req_off} + (req_bank[0] ? GPR1_SHIFT : GPR0_SHIFT); // see R3
  assign req_idx = gpr_hit ? gpr_idx : sfr_idx;

  // A miss reads as zero; the byte the store returns for it is discarded.
  // Gating here rather than in the store keeps empty slots from leaking stale bytes.
  assign next_rdata = req_hit ? rd_byte : ZERO_BYTE; // see R6

  // The write reuses the target latched at the read, so a missed
  // target stays missed even if the pointer changes in between.
  assign store_we = write_phase && OP_WE_I && lat_hit; // see R6, see R7

  bdm_byte_store #(
    .DEPTH(MEM_DEPTH),
    .TAP_A(int'(SLOT_FLAGS)),
    .TAP_B(int'(SLOT_POINTER))
  ) bdm_byte_store_i (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ridx_i(req_idx),
    .rdata_o(rd_byte),
    .we_i(store_we),
    .widx_i(lat_idx),
    .wdata_i(OP_WDATA_I),
    .tap_a_o(flags),
    .tap_b_o(pointer)
  );

  // Operand read: the target and its data are captured in the second quarter.
  // Latching the target here lets the write skip a second decode in the fourth quarter.
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      OP_RDATA_O <= ZERO_BYTE;
      EFF_ADDR_O <= 9'h000;
      EFF_HIT_O <= 1'b0;
      lat_idx <= 8'h00;
      lat_hit <= 1'b0;
    end
    else if (read_phase) // see R7
    begin
      OP_RDATA_O <= next_rdata;
      EFF_ADDR_O <= req_addr;
      EFF_HIT_O <= req_hit;
      lat_idx <= req_idx;
      lat_hit <= req_hit;
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  // Direct accesses take the bank from the flags register.
  bank_direct_a: assert property ( // see R1
    (read_phase && !is_indirect) |=> EFF_ADDR_O[8:7] == $past(flags[FLAGS_BANK_HI:FLAGS_BANK_LO]))
    else $error("bank field not taken from flags");

  // The in-bank offset passes unchanged into the address.
  offset_span_a: assert property ( // see R2
    (read_phase && !is_indirect) |=> EFF_ADDR_O[6:0] == $past(OP_ADDR_I))
    else $error("in-bank offset altered");

  // Bank 0 RAM offsets land in the RAM part of the store.
  gpr_region_a: assert property ( // see R3
    (read_phase && !is_indirect && bank_sel == 2'h0 && OP_ADDR_I >= GPR_BASE)
    |=> lat_hit && lat_idx >= GPR0_BASE_IDX)
    else $error("bank 0 RAM offset missed");

  // Low offsets never reach RAM slots.
  sfr_region_a: assert property ( // see R3
    (read_phase && req_hit && req_off < GPR_BASE) |-> req_idx < GPR0_BASE_IDX)
    else $error("register offset reached RAM");

  // The flags byte answers at its offset in both banks.
  mirror_flags_a: assert property ( // see R4
    (read_phase && bank_ok && req_off == ADR_CPU_FLAGS_B0[6:0])
    |=> EFF_HIT_O && OP_RDATA_O == $past(flags))
    else $error("mirrored flags not shared");

  // Indirect accesses use the pointer.
  indirect_addr_a: assert property ( // see R5
    (read_phase && is_indirect)
    |=> EFF_ADDR_O == {$past(flags[FLAGS_BANK_HI]), $past(pointer)})
    else $error("indirect address not from pointer");

  // The indirect port addressed through itself is empty.
  indirect_self_a: assert property ( // see R8
    (read_phase && is_indirect && pointer[6:0] == OFF_INDIRECT)
    |=> !EFF_HIT_O && OP_RDATA_O == ZERO_BYTE)
    else $error("indirect port read a register");

  // Missing locations read zero.
  unimpl_read_a: assert property ( // see R6
    (read_phase && !req_hit) |=> OP_RDATA_O == ZERO_BYTE && !EFF_HIT_O)
    else $error("missing location read nonzero");

  // Writes to missing locations disturb nothing visible.
  unimpl_write_a: assert property ( // see R6
    (write_phase && OP_WE_I && !lat_hit)
    |=> flags == $past(flags) && pointer == $past(pointer))
    else $error("write to missing location stored");

  // Read data changes only after a second quarter.
  read_quarter_a: assert property ( // see R7
    $changed(OP_RDATA_O) |-> $past(read_phase))
    else $error("read outside second quarter");

  // Stored state changes only after a fourth-quarter write.
  write_quarter_a: assert property ( // see R7
    ($changed(flags) || $changed(pointer)) |-> $past(write_phase) && $past(OP_WE_I))
    else $error("write outside fourth quarter");

  // One read quarter every four clocks.
  quarter_seq_a: assert property ( // see R7
    read_phase |=> !read_phase [*3] ##1 read_phase)
    else $error("quarter sequence broken");

  // A flags write takes effect on the very next decode.
  flags_write_a: assert property ( // see R1
    (store_we && lat_idx == SLOT_FLAGS) |=> flags == $past(OP_WDATA_I))
    else $error("flags write lost");

  // Further guards on the decode and on the quarter timing.
  // Most decode guards check EFF_HIT_O and OP_RDATA_O; only bank1_ram_a, absent_write_a, distinct_slot_a and pointer_write_a watch lat_idx or store_we.

  // Selected but absent banks read empty.
  absent_bank_a: assert property ( // see R6
    (read_phase && !bank_ok)
    |=> !EFF_HIT_O && OP_RDATA_O == ZERO_BYTE)
    else $error("absent bank returned data");

  // A write aimed at an absent bank is dropped.
  absent_write_a: assert property ( // see R6
    (write_phase && EFF_ADDR_O[8])
    |-> !store_we)
    else $error("write to absent bank stored");

  // Bank 1 RAM offsets land in the bank 1 RAM block of the store.
  bank1_ram_a: assert property ( // see R3
    (read_phase && !is_indirect && bank_sel == 2'h1 && OP_ADDR_I >= GPR_BASE && OP_ADDR_I <= GPR1_TOP)
    |=> lat_hit && lat_idx[7:5] == 3'h5)
    else $error("bank 1 RAM offset misplaced");

  // Bank 1 offsets above its RAM block are empty.
  bank1_top_a: assert property ( // see R6
    (read_phase && req_bank == 2'h1 && req_off > GPR1_TOP)
    |=> !EFF_HIT_O)
    else $error("bank 1 offset past RAM hit");

  // The top offset of bank 0 is still inside the bank.
  bank0_top_a: assert property ( // see R2
    (read_phase && !is_indirect && bank_sel == 2'h0 && OP_ADDR_I == 7'h7F)
    |=> EFF_HIT_O)
    else $error("bank 0 top offset missed");

  // The pointer byte answers at its offset in both banks.
  mirror_pointer_a: assert property ( // see R4
    (read_phase && bank_ok && req_off == ADR_INDIRECT_POINTER_B0[6:0])
    |=> EFF_HIT_O && OP_RDATA_O == $past(pointer))
    else $error("mirrored pointer not shared");

  // Bank 1 registers that are not shared keep slots of their own.
  distinct_slot_a: assert property ( // see R4
    (read_phase && sfr_hit && req_bank == 2'h1 && !is_mirror)
    |=> lat_idx[5])
    else $error("bank 1 register shares a slot");

  // Offset 00h never resolves to a register, whichever way it is reached.
  indirect_port_a: assert property ( // see R8
    (read_phase && req_off == OFF_INDIRECT)
    |=> !EFF_HIT_O)
    else $error("indirect port hit a register");

  // A pointer write is seen on the next decode.
  pointer_write_a: assert property ( // see R5
    (store_we && lat_idx == SLOT_POINTER)
    |=> pointer == $past(OP_WDATA_I))
    else $error("pointer write lost");

  // The read target stands outside the second quarter.
  read_hold_a: assert property ( // see R7
    !read_phase
    |=> $stable(EFF_ADDR_O) && $stable(EFF_HIT_O))
    else $error("read target moved outside second quarter");

  // The write quarter follows the read quarter by two clocks.
  read_to_write_a: assert property ( // see R7
    read_phase |-> ##2 write_phase)
    else $error("write quarter misplaced");

  // The quarter count wraps after the fourth quarter.
  quarter_wrap_a: assert property ( // see R7
    (QUARTER_O == 2'h3) |=> QUARTER_O == 2'h0)
    else $error("quarter count did not wrap");

  // Main scenarios.
  indirect_read_c: cover property (read_phase && is_indirect && req_hit);
  bank1_ram_write_c: cover property (store_we && lat_idx >= 8'hA0);
  missing_read_c: cover property (read_phase && !req_hit && !is_indirect);
  mirror_bank1_c: cover property (read_phase && req_bank == 2'h1 && is_mirror && sfr_hit);
  absent_bank_c: cover property (read_phase && !bank_ok);

endmodule : bdm_data_map
`default_nettype wire

// ==== bench/bdm_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Core operand path: one instruction every four clocks, driven 1 ns after each edge.
module bdm_core_model
  import bdm_pkg::*;
(
  input wire logic clk_i,
  input wire logic [1:0] quarter_i,
  input wire logic [7:0] rdata_i,
  input wire logic [8:0] eff_addr_i,
  input wire logic eff_hit_i,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o,
  output logic we_o
);
  // Idle levels; the write data never keeps showing the last byte written.
  initial
  begin
    addr_o = 7'h7F;
    wdata_o = 8'h5A;
    we_o = 1'b0;
  end

  // Step to the cycle of quarter q, giving up after eight clocks so a stuck counter cannot hang us.
  task automatic wait_q(input logic [1:0] q);
    int n;
    n = 0;
    while (quarter_i !== q && n < 8)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask : wait_q

  // One instruction: offset held all through, operand taken in quarter 3, write offered in quarter 4.
  task automatic exec(input logic [6:0] addr, input logic [7:0] wdata, input logic we,
                      output logic [7:0] rdata, output logic [8:0] eff, output logic hit);
    wait_q(2'h0);
    addr_o = addr;
    wait_q(2'h2);
    rdata = rdata_i;
    eff = eff_addr_i;
    hit = eff_hit_i;
    wait_q(2'h3);
    we_o = we;
    wdata_o = wdata;
    wait_q(2'h0);
    we_o = 1'b0;
    wdata_o = ~wdata;
  endtask : exec
endmodule : bdm_core_model
`default_nettype wire

// ==== bench/tb_bdm_data_map.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_bdm_data_map
  import bdm_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] op_addr;
  logic [7:0] op_wdata;
  logic op_we;
  logic [7:0] rdata;
  logic [1:0] quarter;
  logic [8:0] eff_addr;
  logic eff_hit;
  logic [1:0] bank_sel;
  logic [7:0] pointer;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  bdm_data_map bdm_data_map_i (.CLK_I(clk), .RST_I(rst), .OP_ADDR_I(op_addr), .OP_WDATA_I(op_wdata),
    .OP_WE_I(op_we), .OP_RDATA_O(rdata), .QUARTER_O(quarter), .EFF_ADDR_O(eff_addr), .EFF_HIT_O(eff_hit),
    .BANK_SEL_O(bank_sel), .POINTER_O(pointer));
  bdm_core_model bdm_core_model_i (.clk_i(clk), .quarter_i(quarter), .rdata_i(rdata), .eff_addr_i(eff_addr),
    .eff_hit_i(eff_hit), .addr_o(op_addr), .wdata_o(op_wdata), .we_o(op_we));

  // A hang is cut short well beyond the few hundred clocks the run needs.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Reset also clears the bank field, which is the only way back from the absent banks.
  task automatic do_reset();
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("quarter in reset", {7'h00, quarter}, 9'h000);
    check("bank in reset", {7'h00, bank_sel}, 9'h000);
    check("pointer in reset", {1'b0, pointer}, 9'h000);
    rst = 1'b0;
  endtask : do_reset

  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic [8:0] ea, input logic eh);
    logic [7:0] d;
    logic [8:0] e;
    logic h;
    bdm_core_model_i.exec(a, 8'h00, 1'b0, d, e, h);
    check("read data", {1'b0, d}, {1'b0, exp});
    check("effective address", e, ea);
    check("hit", {8'h00, h}, {8'h00, eh});
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] d;
    logic [8:0] e;
    logic h;
    bdm_core_model_i.exec(a, v, 1'b1, d, e, h);
  endtask : wr

  // The quarter counter must step by one each clock, wrapping after the fourth.
  task automatic t_quarter();
    logic [1:0] q;
    @(posedge clk);
    #1;
    q = quarter;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      check("quarter step", {7'h00, quarter}, {7'h00, q + 2'h1});
      q = quarter;
    end
  endtask : t_quarter

  // Every bank value; banks 2 and 3 exist in the address but hold nothing.
  task automatic t_banks();
    logic [7:0] v;
    for (int b = 0; b < 4; b++)
    begin
      if (b == 3)
        do_reset();
      v = {6'h04, b[1:0]};
      wr(7'h03, {1'b0, b[1:0], 5'h00});
      check("bank select", {7'h00, bank_sel}, {7'h00, b[1:0]});
      wr(7'h21, v);
      rd(7'h21, (b < 2) ? v : 8'h00, {b[1:0], 7'h21}, b < 2);
    end
    do_reset();
  endtask : t_banks

  // Shared registers answer in both banks, distinct ones keep their own bytes.
  task automatic t_mirror();
    wr(7'h0A, 8'h3C);
    wr(7'h01, 8'h11);
    wr(7'h03, 8'h20);
    rd(7'h0A, 8'h3C, 9'h08A, 1'b1);
    rd(7'h03, 8'h20, 9'h083, 1'b1);
    rd(7'h01, 8'h00, 9'h081, 1'b1);
    wr(7'h01, 8'h22);
    wr(7'h03, 8'h00);
    rd(7'h01, 8'h11, 9'h001, 1'b1);
  endtask : t_mirror

  // Holes and the edges of RAM, each written and read back.
  task automatic t_unimpl();
    logic [8:0] adr [9] = '{9'h008, 9'h00D, 9'h018, 9'h01D, 9'h08F, 9'h09E, 9'h0C0, 9'h0BF, 9'h07F};
    for (int i = 0; i < 9; i++)
    begin
      wr(7'h03, {1'b0, adr[i][8:7], 5'h00});
      wr(adr[i][6:0], 8'hC3);
      rd(adr[i][6:0], (i > 6) ? 8'hC3 : 8'h00, adr[i], i > 6);
    end
    wr(7'h03, 8'h00);
  endtask : t_unimpl

  // Offset 00 goes through the pointer, pointer bit 7 picking the bank.
  task automatic t_indirect();
    logic [7:0] d;
    logic [8:0] e;
    logic h;
    wr(7'h04, 8'hA1);
    check("pointer", {1'b0, pointer}, 9'h0A1);
    wr(7'h00, 8'h77);
    rd(7'h00, 8'h77, 9'h0A1, 1'b1);
    wr(7'h03, 8'h20);
    rd(7'h21, 8'h77, 9'h0A1, 1'b1);
    wr(7'h04, 8'h25);
    wr(7'h00, 8'h99);
    wr(7'h03, 8'h00);
    rd(7'h25, 8'h99, 9'h025, 1'b1);
    wr(7'h04, 8'h00);
    wr(7'h00, 8'h55);
    bdm_core_model_i.exec(7'h00, 8'h00, 1'b0, d, e, h);
    check("self indirect", {1'b0, d}, 9'h000);
    check("self indirect hit", {8'h00, h}, 9'h000);
    check("self indirect address", e, 9'h000);
  endtask : t_indirect

  // Main sequence.
  initial
  begin
    do_reset();
    t_quarter();
    t_banks();
    t_mirror();
    t_unimpl();
    t_indirect();
    report_and_stop();
  end
endmodule : tb_bdm_data_map
`default_nettype wire
